// ===== src/pmic_cfg_consts.svh
`ifndef PMIC_CFG_CONSTS_SVH
`define PMIC_CFG_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_DISCHARGE 8'h54
`define OFS_CONVCFG 8'h55
`define OFS_RAIL1 8'h56
`define OFS_RAIL2 8'h57

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_DISCHARGE 8'h00
`define RST_CONVCFG 8'h00
`define RST_RAIL1 8'h00
`define RST_RAIL2 8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RAIL5_DIS_MSB 7
`define RAIL5_DIS_LSB 6
`define LINREG_DIS_MSB 5
`define LINREG_DIS_LSB 4
`define CUR_EN_BIT 7
`define VOLT_EN_BIT 6
`define AVG_SEL_MSB 5
`define AVG_SEL_LSB 4
`define OVC_MODE_BIT 3

// ----------------------------------------------------------------------------
// Voltage code scaling and timing
// ----------------------------------------------------------------------------
`define VOUT_BASE_MV 16'h012C
`define VOUT_STEP_FULL_MV 16'h000A
`define VOUT_STEP_HALF_MV 16'h0014
`define VCODE_TOP_FULL 8'hB4
`define VCODE_TOP_HALF 8'h9E
`define AVG_MS_SEL0 3'h1
`define AVG_MS_SEL1 3'h2
`define AVG_MS_SEL2 3'h4
`define AVG_MS_SEL3 3'h5
`define CLK_PERIOD_NS 32'h0000_0008
`define MS_IN_NS 32'h000F_4240

`endif

// ===== src/pmic_cfg_pkg.sv
package pmic_cfg_pkg;

  // Serial port receiver and transmitter phases.
  typedef enum logic [2:0] {
    I_IDLE,
    I_ADDR,
    I_ADDR_ACK,
    I_RX,
    I_RX_ACK,
    I_TX,
    I_TX_ACK
  } serial_state_t;

  // Whole state of the register bank.
  typedef struct packed {
    logic sclPrev;
    logic sdaPrev;
    serial_state_t st;
    logic [3:0] bitCnt;
    logic [7:0] shreg;
    logic rw;
    logic havePtr;
    logic masterAck;
    logic sdaOe;
    logic [7:0] ptr;
    logic [7:0] dischargeCfg;
    logic [7:0] convCfg;
    logic [7:0] rail1Code;
    logic [7:0] rail2Code;
    logic cfgWritePulse;
    logic clrCurrent;
    logic clrVoltage;
    logic ovcFlag;
    logic [3:0] rail5Bleed;
    logic [3:0] linregBleed;
    logic [15:0] rail1Mv;
    logic [15:0] rail2Mv;
  } ctrl_state_t;

endpackage

// ===== src/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Three-stage synchroniser; the level moves only once stages one and two agree.
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Pin and clean level.
  input wire logic pinIn,
  output logic level
);
  typedef struct packed {
    logic [2:0] stages;
    logic level;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next;

  // Stage zero feeds stage one only, so no logic sees a metastable value.
  always_comb begin
    next = s;
    next.stages = {s.stages[1:0], pinIn};
    if (s.stages[1] == s.stages[2]) begin
      next.level = s.stages[2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= {{3{RESET_LEVEL}}, RESET_LEVEL};
    end else begin
      s <= next;
    end
  end

  assign level = s.level;
endmodule

`default_nettype wire

// ===== src/avg_window_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmic_cfg_consts.svh"

// Averaging window timer: pulses once per selected number of milliseconds.
module avg_window_timer #(
  parameter int CYCLES_PER_MS = `MS_IN_NS / `CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Control.
  input wire logic run,
  input wire logic restart,
  input wire logic [1:0] windowSel,
  // Window end.
  output logic windowDone
);
  localparam int TW = $clog2(CYCLES_PER_MS + 1);

  if (CYCLES_PER_MS < 1) begin : g_bad_cycles
    $error("CYCLES_PER_MS must be at least one");
  end

  typedef struct packed {
    logic [TW-1:0] tick;
    logic [2:0] msCnt;
    logic [2:0] targetMs;
    logic done;
  } timer_state_t;

  timer_state_t s;
  timer_state_t next;

  function automatic logic [2:0] windowMs(input logic [1:0] sel);
    case (sel)
      2'h0: return `AVG_MS_SEL0;
      2'h1: return `AVG_MS_SEL1;
      2'h2: return `AVG_MS_SEL2;
      default: return `AVG_MS_SEL3;
    endcase
  endfunction

  // A restart throws away the partial window, so a new setting never
  // inherits samples taken under the old one.
  always_comb begin
    next = s;
    next.done = 1'b0;
    if (restart || !run) begin
      next.tick = '0;
      next.msCnt = 3'h0;
      next.targetMs = windowMs(windowSel);
    end else if (s.tick == TW'(CYCLES_PER_MS - 1)) begin
      next.tick = '0;
      if (s.msCnt == s.targetMs - 3'h1) begin
        next.msCnt = 3'h0;
        next.done = 1'b1;
        next.targetMs = windowMs(windowSel);
      end else begin
        next.msCnt = s.msCnt + 3'h1;
      end
    end else begin
      next.tick = s.tick + TW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next;
    end
  end

  assign windowDone = s.done;

  property p_restart_clears;
    @(posedge clk) disable iff (!rstn)
    restart |=> s.tick == '0 && s.msCnt == 3'h0 && !windowDone;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("restart did not clear");

  property p_window_len;
    @(posedge clk) disable iff (!rstn)
    (restart && run && windowSel == 2'h3) |=> s.targetMs == 3'h5;
  endproperty
  a_window_len: assert property (p_window_len) else $error("window length not 5 ms");

  property p_window_done;
    @(posedge clk) disable iff (!rstn)
    windowDone |-> $past(s.msCnt) == $past(s.targetMs) - 3'h1;
  endproperty
  c_window_done: cover property (p_window_done);
endmodule

`default_nettype wire

// ===== src/pmic_rail_adc_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmic_cfg_consts.svh"

module pmic_rail_adc_config_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary serial address.
  parameter int CYCLES_PER_MS = `MS_IN_NS / `CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Two-wire serial port; SDA is open drain.
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Status from the rest of the device.
  input wire logic rail1FeedbackHalving,
  input wire logic rail2FeedbackHalving,
  input wire logic overcurrentCondition,
  // Discharge selections.
  output logic [1:0] rail5DischargeSel,
  output logic [1:0] linregDischargeSel,
  output logic [3:0] rail5Bleed,
  output logic [3:0] linregBleed,
  // Monitoring converter control.
  output logic inputCurrentConvEn,
  output logic inputVoltageConvEn,
  output logic [1:0] averagingWindowSel,
  output logic overcurrentFlagMode,
  output logic inputOvercurrentFlag,
  output logic currentAccumClear,
  output logic voltageAccumClear,
  output logic avgRestart,
  output logic avgWindowDone,
  // Rail voltage setpoints.
  output logic [7:0] rail1VoltageCode,
  output logic [7:0] rail2VoltageCode,
  output logic [15:0] rail1SetpointMv,
  output logic [15:0] rail2SetpointMv
);
  import pmic_cfg_pkg::*;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic sclLvl;
  logic sdaLvl;
  logic ovcLvl;

  pin_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
    .clk(clk),
    .rstn(rstn),
    .pinIn(sclIn),
    .level(sclLvl)
  );

  pin_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
    .clk(clk),
    .rstn(rstn),
    .pinIn(sdaIn),
    .level(sdaLvl)
  );

  pin_sync #(.RESET_LEVEL(1'b0)) u_ovc_sync (
    .clk(clk),
    .rstn(rstn),
    .pinIn(overcurrentCondition),
    .level(ovcLvl)
  );

  // --------------------------------------------------------------------------
  // State and bus events
  // --------------------------------------------------------------------------
  ctrl_state_t s;
  ctrl_state_t next;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  // Start and stop are SDA moving while SCL stays high.
  assign sclRise = sclLvl & ~s.sclPrev;
  assign sclFall = ~sclLvl & s.sclPrev;
  assign startCond = sclLvl & s.sclPrev & s.sdaPrev & ~sdaLvl;
  assign stopCond = sclLvl & s.sclPrev & ~s.sdaPrev & sdaLvl;

  function automatic logic [15:0] setpointMv(input logic [7:0] code, input logic half);
    logic [15:0] step;
    step = half ? `VOUT_STEP_HALF_MV : `VOUT_STEP_FULL_MV;
    return 16'(`VOUT_BASE_MV + 16'(16'(code) * step));
  endfunction

  // Unmapped offsets read as zero.
  function automatic logic [7:0] regRead(input ctrl_state_t c);
    case (c.ptr)
      `OFS_DISCHARGE: return c.dischargeCfg;
      `OFS_CONVCFG: return c.convCfg;
      `OFS_RAIL1: return c.rail1Code;
      `OFS_RAIL2: return c.rail2Code;
      default: return 8'h00;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  // Bits are taken on SCL rise and SDA is only changed after SCL falls,
  // so our own drive can never look like a start or stop.
  always_comb begin
    next = s;
    next.sclPrev = sclLvl;
    next.sdaPrev = sdaLvl;
    next.cfgWritePulse = 1'b0;
    if (stopCond) begin
      next.st = I_IDLE;
      next.sdaOe = 1'b0;
    end else if (startCond) begin
      next.st = I_ADDR;
      next.bitCnt = 4'h0;
      next.sdaOe = 1'b0;
      next.havePtr = 1'b0;
    end else begin
      case (s.st)
        I_IDLE: begin
          next.sdaOe = 1'b0;
        end
        I_ADDR, I_RX: begin
          if (sclRise) begin
            next.shreg = {s.shreg[6:0], sdaLvl};
            next.bitCnt = s.bitCnt + 4'h1;
          end else if (sclFall && s.bitCnt == 4'h8) begin
            next.bitCnt = 4'h0;
            if (s.st == I_ADDR) begin
              if (s.shreg[7:1] == DEV_ADDR) begin
                next.sdaOe = 1'b1;
                next.rw = s.shreg[0];
                next.st = I_ADDR_ACK;
              end else begin
                next.st = I_IDLE;
              end
            end else begin
              next.sdaOe = 1'b1;
              next.st = I_RX_ACK;
              if (!s.havePtr) begin
                next.ptr = s.shreg;
                next.havePtr = 1'b1;
              end else begin
                next.ptr = s.ptr + 8'h01;
                case (s.ptr)
                  `OFS_DISCHARGE: next.dischargeCfg = s.shreg;
                  `OFS_CONVCFG: begin
                    next.convCfg = s.shreg;
                    next.cfgWritePulse = 1'b1;
                  end
                  `OFS_RAIL1: next.rail1Code = s.shreg;
                  `OFS_RAIL2: next.rail2Code = s.shreg;
                  default: next.ptr = s.ptr + 8'h01; // Acked and dropped.
                endcase
              end
            end
          end
        end
        I_ADDR_ACK: begin
          if (sclFall) begin
            next.bitCnt = 4'h0;
            if (s.rw) begin
              next.shreg = regRead(s);
              next.sdaOe = ~next.shreg[7];
              next.st = I_TX;
            end else begin
              next.sdaOe = 1'b0;
              next.st = I_RX;
            end
          end
        end
        I_RX_ACK: begin
          if (sclFall) begin
            next.sdaOe = 1'b0;
            next.st = I_RX;
          end
        end
        I_TX: begin
          if (sclRise) begin
            next.bitCnt = s.bitCnt + 4'h1;
          end else if (sclFall) begin
            if (s.bitCnt == 4'h8) begin
              next.sdaOe = 1'b0;
              next.ptr = s.ptr + 8'h01;
              next.st = I_TX_ACK;
            end else begin
              next.shreg = {s.shreg[6:0], 1'b0};
              next.sdaOe = ~s.shreg[6];
            end
          end
        end
        I_TX_ACK: begin
          if (sclRise) begin
            next.masterAck = ~sdaLvl;
          end else if (sclFall) begin
            if (s.masterAck) begin
              next.bitCnt = 4'h0;
              next.shreg = regRead(s);
              next.sdaOe = ~next.shreg[7];
              next.st = I_TX;
            end else begin
              next.st = I_IDLE;
            end
          end
        end
        default: begin
          next.st = I_IDLE;
          next.sdaOe = 1'b0;
        end
      endcase
    end

    // Accumulators are held clear while disabled and flushed on any write to the converter config register.
    next.clrCurrent = ~next.convCfg[`CUR_EN_BIT] | next.cfgWritePulse;
    next.clrVoltage = ~next.convCfg[`VOLT_EN_BIT] | next.cfgWritePulse;

    // In latch mode a new condition wins over the clear from a write.
    if (s.convCfg[`OVC_MODE_BIT]) begin
      next.ovcFlag = ovcLvl;
    end else begin
      next.ovcFlag = ovcLvl | (s.ovcFlag & ~next.cfgWritePulse);
    end

    // One-hot bleed: bit 0 10 ohm, bit 1 20 ohm, bit 2 50 ohm, bit 3 open.
    next.rail5Bleed = 4'h1 << s.dischargeCfg[`RAIL5_DIS_MSB:`RAIL5_DIS_LSB];
    next.linregBleed = 4'h1 << s.dischargeCfg[`LINREG_DIS_MSB:`LINREG_DIS_LSB];

    // Codes past the top code are not clamped; the host keeps them in range.
    next.rail1Mv = setpointMv(s.rail1Code, rail1FeedbackHalving);
    next.rail2Mv = setpointMv(s.rail2Code, rail2FeedbackHalving);
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
      s.sclPrev <= 1'b1;
      s.sdaPrev <= 1'b1;
      s.dischargeCfg <= `RST_DISCHARGE;
      s.convCfg <= `RST_CONVCFG;
      s.rail1Code <= `RST_RAIL1;
      s.rail2Code <= `RST_RAIL2;
      // Derived outputs start as the decode of the zero reset registers, so the
      // first cycles after reset never show a bleed, clear or setpoint that disagrees.
      s.clrCurrent <= 1'b1;
      s.clrVoltage <= 1'b1;
      s.rail5Bleed <= 4'h1;
      s.linregBleed <= 4'h1;
      s.rail1Mv <= `VOUT_BASE_MV;
      s.rail2Mv <= `VOUT_BASE_MV;
    end else begin
      s <= next;
    end
  end

  // --------------------------------------------------------------------------
  // Averaging timer and outputs
  // --------------------------------------------------------------------------
  avg_window_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_avg_timer (
    .clk(clk),
    .rstn(rstn),
    .run(s.convCfg[`CUR_EN_BIT] | s.convCfg[`VOLT_EN_BIT]),
    .restart(s.cfgWritePulse),
    .windowSel(s.convCfg[`AVG_SEL_MSB:`AVG_SEL_LSB]),
    .windowDone(avgWindowDone)
  );

  assign sdaOut = 1'b0;
  assign sdaOe = s.sdaOe;
  assign rail5DischargeSel = s.dischargeCfg[`RAIL5_DIS_MSB:`RAIL5_DIS_LSB];
  assign linregDischargeSel = s.dischargeCfg[`LINREG_DIS_MSB:`LINREG_DIS_LSB];
  assign rail5Bleed = s.rail5Bleed;
  assign linregBleed = s.linregBleed;
  assign inputCurrentConvEn = s.convCfg[`CUR_EN_BIT];
  assign inputVoltageConvEn = s.convCfg[`VOLT_EN_BIT];
  assign averagingWindowSel = s.convCfg[`AVG_SEL_MSB:`AVG_SEL_LSB];
  assign overcurrentFlagMode = s.convCfg[`OVC_MODE_BIT];
  assign inputOvercurrentFlag = s.ovcFlag;
  assign currentAccumClear = s.clrCurrent;
  assign voltageAccumClear = s.clrVoltage;
  assign avgRestart = s.cfgWritePulse;
  assign rail1VoltageCode = s.rail1Code;
  assign rail2VoltageCode = s.rail2Code;
  assign rail1SetpointMv = s.rail1Mv;
  assign rail2SetpointMv = s.rail2Mv;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_rail5_bleed;
    @(posedge clk) disable iff (!rstn)
    $past(rail5DischargeSel) == 2'h3 |-> rail5Bleed == 4'h8;
  endproperty
  a_rail5_bleed: assert property (p_rail5_bleed) else $error("rail5 not open");

  property p_linreg_bleed;
    @(posedge clk) disable iff (!rstn)
    1'b1 |=> linregBleed == 4'(4'h1 << $past(linregDischargeSel));
  endproperty
  a_linreg_bleed: assert property (p_linreg_bleed) else $error("linreg bleed wrong");

  property p_disable_clears;
    @(posedge clk) disable iff (!rstn)
    !inputCurrentConvEn |-> currentAccumClear;
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("accum not cleared");

  property p_write_restart;
    @(posedge clk) disable iff (!rstn)
    avgRestart |-> currentAccumClear && voltageAccumClear ##1 !avgWindowDone;
  endproperty
  a_write_restart: assert property (p_write_restart) else $error("write no restart");

  property p_ovc_latch;
    @(posedge clk) disable iff (!rstn)
    (!overcurrentFlagMode && inputOvercurrentFlag) ##1 !avgRestart |-> inputOvercurrentFlag;
  endproperty
  a_ovc_latch: assert property (p_ovc_latch) else $error("flag not latched");

  property p_ovc_free;
    @(posedge clk) disable iff (!rstn)
    overcurrentFlagMode |=> inputOvercurrentFlag == $past(ovcLvl);
  endproperty
  a_ovc_free: assert property (p_ovc_free) else $error("flag not free running");

  property p_rail1_full;
    @(posedge clk) disable iff (!rstn)
    !rail1FeedbackHalving && rail1VoltageCode == `VCODE_TOP_FULL |=> rail1SetpointMv == 16'h0834;
  endproperty
  a_rail1_full: assert property (p_rail1_full) else $error("rail1 top not 2.1 V");

  property p_rail1_half;
    @(posedge clk) disable iff (!rstn)
    rail1FeedbackHalving |=> rail1SetpointMv == 16'(300 + 20 * $past(rail1VoltageCode));
  endproperty
  a_rail1_half: assert property (p_rail1_half) else $error("rail1 half scale wrong");

  property p_rail2_full;
    @(posedge clk) disable iff (!rstn)
    !rail2FeedbackHalving |=> rail2SetpointMv == 16'(300 + 10 * $past(rail2VoltageCode));
  endproperty
  a_rail2_full: assert property (p_rail2_full) else $error("rail2 full scale wrong");

  property p_rail2_half;
    @(posedge clk) disable iff (!rstn)
    rail2FeedbackHalving && rail2VoltageCode == `VCODE_TOP_HALF |=> rail2SetpointMv == 16'h0D84;
  endproperty
  a_rail2_half: assert property (p_rail2_half) else $error("rail2 top not 3.46 V");

  property p_reserved_inert;
    @(posedge clk) disable iff (!rstn)
    $stable(s.dischargeCfg[7:4]) |=> $stable(rail5Bleed) && $stable(linregBleed);
  endproperty
  a_reserved_inert: assert property (p_reserved_inert) else $error("reserved bits act");

  property p_cfg_write;
    @(posedge clk) disable iff (!rstn)
    avgRestart ##1 s.st == I_RX_ACK;
  endproperty
  c_cfg_write: cover property (p_cfg_write);

  property p_read_byte;
    @(posedge clk) disable iff (!rstn)
    s.st == I_TX && next.st == I_TX_ACK;
  endproperty
  c_read_byte: cover property (p_read_byte);

  property p_latched_flag;
    @(posedge clk) disable iff (!rstn)
    inputOvercurrentFlag && !ovcLvl && !overcurrentFlagMode;
  endproperty
  c_latched_flag: cover property (p_latched_flag);
endmodule

`default_nettype wire

// ===== test/i2c_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// --------
// Host controller on the two-wire bus
// --------
// Bit-level host; every line moves just after a rising clock edge. SDA is only ever pulled low
// or released, so a released line reads high through the pull-up that the bench models.
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary serial address.
) (
  // Clock.
  input wire logic clk,
  // Bus lines.
  input wire logic sdaWire,
  output logic scl,
  output logic sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // Twelve clocks per half period keeps well clear of the 10-clock minimum.
  task automatic half();
    repeat (12) @(posedge clk);
  endtask

  // SDA moves three clocks after SCL falls, so it never races the falling edge.
  task automatic bitX(input logic b, output logic s);
    repeat (3) @(posedge clk);
    sdaLow <= ~b;
    half();
    scl <= 1'b1;
    half();
    @(negedge clk) s = sdaWire;
    @(posedge clk) scl <= 1'b0;
  endtask

  task automatic byteX(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bitX(d[i], r[i]);
  endtask

  // Serves as a first or a repeated start.
  task automatic start();
    repeat (3) @(posedge clk);
    sdaLow <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sdaLow <= 1'b1;
    half();
    scl <= 1'b0;
  endtask

  task automatic stop();
    repeat (3) @(posedge clk);
    sdaLow <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sdaLow <= 1'b0;
    half();
  endtask

  // Ack is high only if all three bytes were acknowledged.
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d, output logic ack);
    logic [7:0] r;
    logic a, b, c;
    start();
    byteX({DEV_ADDR, 1'b0}, r);
    bitX(1'b1, a);
    byteX(ofs, r);
    bitX(1'b1, b);
    byteX(d, r);
    bitX(1'b1, c);
    stop();
    ack = ~(a | b | c);
  endtask

  // One byte is read and ended with a not-acknowledge.
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic [7:0] r;
    logic a;
    start();
    byteX({DEV_ADDR, 1'b0}, r);
    bitX(1'b1, a);
    byteX(ofs, r);
    bitX(1'b1, a);
    start();
    byteX({DEV_ADDR, 1'b1}, r);
    bitX(1'b1, a);
    byteX(8'hFF, d);
    bitX(1'b1, a);
    stop();
  endtask
endmodule
`default_nettype wire

// ===== test/test_pmic_rail_adc_config_regs.sv
`timescale 1ns/10ps
`default_nettype none

module test_pmic_rail_adc_config_regs;
  typedef struct packed {
    logic [7:0] ofs;
    logic [7:0] data;
    logic halv;
    logic [15:0] exp;
  } row_t;

  // --------
  // Signals
  // --------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sclIn, sdaLow, sdaOe;
  logic rail1FeedbackHalving = 1'b0;
  logic rail2FeedbackHalving = 1'b0;
  logic overcurrentCondition = 1'b0;
  logic [1:0] rail5DischargeSel, linregDischargeSel, averagingWindowSel;
  logic [3:0] rail5Bleed, linregBleed;
  logic inputCurrentConvEn, inputVoltageConvEn, overcurrentFlagMode, inputOvercurrentFlag;
  logic currentAccumClear, voltageAccumClear, avgRestart, avgWindowDone;
  logic [7:0] rail1VoltageCode, rail2VoltageCode, rdData;
  logic [15:0] rail1SetpointMv, rail2SetpointMv, obs;
  logic ack;
  wire logic sdaIn = ~(sdaLow | sdaOe);
  int failures = 0;
  int n_compared = 0;
  int nRestart = 0;
  int nClr = 0;
  int n0, c0, n;
  int winMs[4] = '{1, 2, 4, 5};
  // Codes stay within the top code of the ratio in use.
  // The 0x7F row changes only the reserved bits, so the bleed must not move.
  row_t rows[12] = '{'{8'h54, 8'h1B, 1'b0, 16'h0012}, '{8'h54, 8'hE5, 1'b0, 16'h0084},
    '{8'h54, 8'h9A, 1'b0, 16'h0042}, '{8'h54, 8'h70, 1'b0, 16'h0028},
    '{8'h54, 8'h7F, 1'b0, 16'h0028},
    '{8'h56, 8'hB4, 1'b0, 16'h0834}, '{8'h56, 8'h9E, 1'b1, 16'h0D84},
    '{8'h56, 8'h00, 1'b0, 16'h012C}, '{8'h57, 8'h01, 1'b0, 16'h0136},
    '{8'h57, 8'hB4, 1'b0, 16'h0834}, '{8'h57, 8'h9E, 1'b1, 16'h0D84},
    '{8'h57, 8'h00, 1'b1, 16'h012C}};

  always #4 clk = ~clk;

  pmic_rail_adc_config_regs #(.CYCLES_PER_MS(4)) u_dut (.clk, .rstn, .sclIn, .sdaIn,
    .sdaOut(), .sdaOe, .rail1FeedbackHalving, .rail2FeedbackHalving, .overcurrentCondition,
    .rail5DischargeSel, .linregDischargeSel, .rail5Bleed, .linregBleed, .inputCurrentConvEn,
    .inputVoltageConvEn, .averagingWindowSel, .overcurrentFlagMode, .inputOvercurrentFlag,
    .currentAccumClear, .voltageAccumClear, .avgRestart, .avgWindowDone, .rail1VoltageCode,
    .rail2VoltageCode, .rail1SetpointMv, .rail2SetpointMv);

  i2c_host_model u_host (.clk, .sdaWire(sdaIn), .scl(sclIn), .sdaLow);

  // Counts restart pulses and cycles with both clears high, to see one per write.
  always @(posedge clk) begin
    if (avgRestart === 1'b1) nRestart <= nRestart + 1;
    if ((currentAccumClear & voltageAccumClear) === 1'b1) nClr <= nClr + 1;
  end

  // --------
  // Helpers
  // --------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Measures the spacing of two window-end pulses, bounded so a dead timer cannot hang.
  task automatic per(output int p);
    p = 0;
    for (int k = 0; k < 200 && avgWindowDone !== 1'b1; k++) @(negedge clk);
    do begin
      @(negedge clk);
      p++;
    end while (avgWindowDone !== 1'b1 && p < 200);
  endtask

  task automatic test_done();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Whole run is near 40000 clocks; twice that means a hang.
  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    test_done();
  end

  // --------
  // Tests
  // --------
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(negedge clk);
    chk(rail5Bleed, 16'h1);
    chk(rail1SetpointMv, 16'h012C);
    chk(currentAccumClear, 16'h1);
    for (int i = 0; i < 4; i++) begin
      u_host.rd(8'h54 + 8'(i), rdData);
      chk(rdData, 16'h0);
    end
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clk);
      rail1FeedbackHalving <= rows[i].halv;
      rail2FeedbackHalving <= rows[i].halv;
      u_host.wr(rows[i].ofs, rows[i].data, ack);
      chk(ack, 16'h1);
      u_host.rd(rows[i].ofs, rdData);
      chk(rdData, rows[i].data);
      @(negedge clk);
      case (rows[i].ofs)
        8'h54: obs = {8'h00, rail5Bleed, linregBleed};
        8'h56: obs = rail1SetpointMv;
        default: obs = rail2SetpointMv;
      endcase
      chk(obs, rows[i].exp);
      case (rows[i].ofs)
        8'h54: obs = {12'h000, rail5DischargeSel, linregDischargeSel};
        8'h56: obs = {8'h00, rail1VoltageCode};
        default: obs = {8'h00, rail2VoltageCode};
      endcase
      chk(obs, rows[i].ofs == 8'h54 ? 16'(rows[i].data[7:4]) : 16'(rows[i].data));
    end
    $display("test table done");
    // Enables go on first, so each loop write shows only its one-cycle clear pulse.
    u_host.wr(8'h55, 8'hC8, ack);
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      n0 = nRestart;
      c0 = nClr;
      u_host.wr(8'h55, {2'b11, 2'(i % 4), 4'h8}, ack);
      @(negedge clk);
      chk(16'(nRestart - n0), 16'h1);
      chk(16'(nClr - c0), 16'h1);
      chk(averagingWindowSel, 16'(i % 4));
      chk({inputCurrentConvEn, inputVoltageConvEn}, 16'h3);
      per(n);
      chk(16'(n), 16'(winMs[i % 4] * 4));
    end
    $display("test averaging done");
    u_host.wr(8'h55, 8'h48, ack);
    @(negedge clk);
    chk({currentAccumClear, voltageAccumClear}, 16'h2);
    u_host.wr(8'h55, 8'h88, ack);
    @(negedge clk);
    chk({currentAccumClear, voltageAccumClear}, 16'h1);
    @(posedge clk) overcurrentCondition <= 1'b1;
    repeat (8) @(negedge clk);
    chk(inputOvercurrentFlag, 16'h1);
    @(posedge clk) overcurrentCondition <= 1'b0;
    repeat (8) @(negedge clk);
    chk(inputOvercurrentFlag, 16'h0);
    u_host.wr(8'h55, 8'h80, ack);
    @(posedge clk) overcurrentCondition <= 1'b1;
    repeat (8) @(posedge clk);
    overcurrentCondition <= 1'b0;
    repeat (8) @(negedge clk);
    chk({overcurrentFlagMode, inputOvercurrentFlag}, 16'h1);
    u_host.wr(8'h55, 8'h80, ack);
    @(negedge clk);
    chk(inputOvercurrentFlag, 16'h0);
    $display("test overcurrent done");
    u_host.wr(8'h60, 8'hA5, ack);
    chk(ack, 16'h1);
    u_host.rd(8'h60, rdData);
    chk(rdData, 16'h0);
    $display("test unmapped done");
    // A reset in mid-run must bring the discharge and converter config registers back to their reset values.
    @(posedge clk) rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(negedge clk);
    chk(16'({rail5DischargeSel, linregDischargeSel, inputCurrentConvEn, currentAccumClear}), 16'h1);
    $display("test reset again done");
    test_done();
  end
endmodule
`default_nettype wire
